//--- inc/fpg_map.svh
/*
  Constants of the flash program/erase guard: key codes, flash geometry, lock byte place.
  Assumes a 16 KB flash of 512-byte pages with the top page reserved.
*/
`ifndef FPG_MAP_SVH
`define FPG_MAP_SVH
`define FPG_KEY_FIRST  8'ha5
`define FPG_KEY_SECOND 8'hf1
`define FPG_ERASED     8'hff
`define FPG_ADDR_W     14
`define FPG_PAGE_LSB   9
`define FPG_PAGE_W     5
`define FPG_PAGE_LAST  9'h1ff
`define FPG_RSV_PAGE   5'h1f
`define FPG_LOCK_PAGE  5'h1e
`define FPG_LOCK_ADDR  14'h3dff
`define FPG_FLASH_LAST 14'h3fff
`endif

//--- inc/fpg_pkg.sv
/*
  Types of the flash program/erase guard.
  Assumes fpg_map.svh is on the include path.
*/
package fpg_pkg;
  typedef enum logic [3:0] {
    FPG_K_LOCKED = 4'b0001,
    FPG_K_FIRST  = 4'b0010,
    FPG_K_ARMED  = 4'b0100,
    FPG_K_BLOCK  = 4'b1000
  } fpg_key_t;
  typedef enum logic [2:0] {
    FPG_S_IDLE  = 3'b001,
    FPG_S_ERASE = 3'b010,
    FPG_S_WIPE  = 3'b100
  } fpg_op_t;
  typedef enum logic [1:0] {
    FPG_D_READ  = 2'h0,
    FPG_D_WRITE = 2'h1,
    FPG_D_ERASE = 2'h2,
    FPG_D_WIPE  = 2'h3
  } fpg_dbg_t;
endpackage : fpg_pkg

//--- logic/fpg_guard.sv
/*
  Flash program/erase guard with its own flash array, key lock, page lock and debug path.
  Assumes the core presents one write, read or control access per cycle on clk_sys and
  waits while stall is high; the debug port is logic on the same clock.
*/
`include "fpg_map.svh"
module fpg_guard
  import fpg_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   key_wr,
  input  wire logic [7:0]             key_data,
  input  wire logic                   ctl_wr,
  input  wire logic                   ctl_write_en,
  input  wire logic                   ctl_erase_en,
  input  wire logic                   xwr,
  input  wire logic                   xrd,
  input  wire logic [`FPG_ADDR_W-1:0] x_addr,
  input  wire logic [7:0]             x_wdata,
  input  wire logic [`FPG_ADDR_W-1:0] exec_addr,
  input  wire logic                   code_rd,
  input  wire logic [`FPG_ADDR_W-1:0] code_addr,
  input  wire logic                   dbg_req,
  input  wire fpg_dbg_t               dbg_cmd,
  input  wire logic [`FPG_ADDR_W-1:0] dbg_addr,
  input  wire logic [7:0]             dbg_wdata,
  output logic                        store_write_enable,
  output logic                        store_erase_enable,
  output logic                        key_armed,
  output logic                        key_blocked,
  output logic                        stall,
  output logic                        ram_wr,
  output logic                        ram_rd,
  output logic [`FPG_ADDR_W-1:0]      ram_addr,
  output logic [7:0]                  ram_wdata,
  output logic [7:0]                  code_rdata,
  output logic                        dbg_ack,
  output logic                        dbg_refused,
  output logic [7:0]                  dbg_rdata,
  output logic                        flash_err_rst
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [7:0]               mem [0:`FPG_FLASH_LAST];
  fpg_key_t                 key_state;
  fpg_op_t                  op_state;
  logic [`FPG_ADDR_W-1:0]   er_addr;
  logic [7:0]               lock_byte;
  logic                     exec_locked;
  logic                     flash_wr;
  logic                     fw_allowed;
  logic                     code_allowed;
  logic                     dbg_allowed;
  logic                     busy;

  function automatic logic page_locked(input logic [`FPG_ADDR_W-1:0] a, input logic [7:0] lb);
    logic [7:0] n;
    n = ~lb;
    page_locked = ({3'h0, a[`FPG_ADDR_W-1:`FPG_PAGE_LSB]} < n)
      || (lb != `FPG_ERASED && a[`FPG_ADDR_W-1:`FPG_PAGE_LSB] == `FPG_LOCK_PAGE);
  endfunction : page_locked

  function automatic logic is_rsv(input logic [`FPG_ADDR_W-1:0] a);
    is_rsv = a[`FPG_ADDR_W-1:`FPG_PAGE_LSB] == `FPG_RSV_PAGE;
  endfunction : is_rsv

  assign lock_byte   = mem[`FPG_LOCK_ADDR];
  assign exec_locked = page_locked(exec_addr, lock_byte);
  assign busy        = op_state != FPG_S_IDLE;
  assign stall       = busy;
  assign flash_wr    = xwr && store_write_enable && !busy;
  assign ram_rd      = xrd;
  assign key_armed   = key_state == FPG_K_ARMED;
  assign key_blocked = key_state == FPG_K_BLOCK;

  always_comb begin
    fw_allowed = !is_rsv(x_addr);
    if (exec_locked) begin
      if (store_erase_enable && x_addr[`FPG_ADDR_W-1:`FPG_PAGE_LSB] == `FPG_LOCK_PAGE) begin
        fw_allowed = 1'b0;
      end
    end else if (page_locked(x_addr, lock_byte)) begin
      fw_allowed = 1'b0;
    end
    code_allowed = exec_locked || !page_locked(code_addr, lock_byte);
    dbg_allowed = (dbg_cmd == FPG_D_WIPE) || !page_locked(dbg_addr, lock_byte);
  end

  // ----------------------------------------
  // Store control
  // ----------------------------------------
  // software-only enables
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      store_write_enable <= 1'b0;
      store_erase_enable <= 1'b0;
    end else if (ctl_wr) begin
      store_write_enable <= ctl_write_en;
      store_erase_enable <= ctl_erase_en;
    end
  end

  // ----------------------------------------
  // Key lock
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      key_state <= FPG_K_LOCKED;
    end else begin
      case (key_state)
        FPG_K_LOCKED: begin
          if (flash_wr) begin
            key_state <= FPG_K_BLOCK;
          end else if (key_wr) begin
            key_state <= (key_data == `FPG_KEY_FIRST) ? FPG_K_FIRST : FPG_K_BLOCK;
          end
        end
        FPG_K_FIRST: begin
          if (flash_wr) begin
            key_state <= FPG_K_BLOCK;
          end else if (key_wr) begin
            key_state <= (key_data == `FPG_KEY_SECOND) ? FPG_K_ARMED : FPG_K_BLOCK;
          end
        end
        FPG_K_ARMED: begin
          if (flash_wr) begin
            key_state <= FPG_K_LOCKED;
          end else if (key_wr) begin
            key_state <= FPG_K_BLOCK;
          end
        end
        FPG_K_BLOCK: key_state <= FPG_K_BLOCK;
        default:     key_state <= FPG_K_BLOCK;
      endcase
    end
  end

  // ----------------------------------------
  // Flash operations
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_state <= FPG_S_IDLE;
      er_addr  <= '0;
    end else begin
      case (op_state)
        FPG_S_IDLE: begin
          if (flash_wr && key_armed && fw_allowed && store_erase_enable) begin
            op_state <= FPG_S_ERASE;
            er_addr  <= {x_addr[`FPG_ADDR_W-1:`FPG_PAGE_LSB], `FPG_PAGE_W'(0), 4'h0};
          end else if (dbg_req && dbg_cmd == FPG_D_WIPE) begin
            op_state <= FPG_S_WIPE;
            er_addr  <= '0;
          end else if (dbg_req && dbg_cmd == FPG_D_ERASE && dbg_allowed) begin
            op_state <= FPG_S_ERASE;
            er_addr  <= {dbg_addr[`FPG_ADDR_W-1:`FPG_PAGE_LSB], `FPG_PAGE_W'(0), 4'h0};
          end
        end
        FPG_S_ERASE: begin
          er_addr <= er_addr + 14'h1;
          if (er_addr[`FPG_PAGE_LSB-1:0] == `FPG_PAGE_LAST) begin
            op_state <= FPG_S_IDLE;
          end
        end
        FPG_S_WIPE: begin
          er_addr <= er_addr + 14'h1;
          if (er_addr == `FPG_FLASH_LAST) begin
            op_state <= FPG_S_IDLE;
          end
        end
        default: op_state <= FPG_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (busy) begin
      mem[er_addr] <= `FPG_ERASED;
    end else if (flash_wr && key_armed && fw_allowed && !store_erase_enable) begin
      mem[x_addr] <= mem[x_addr] & x_wdata;
    end else if (dbg_req && dbg_cmd == FPG_D_WRITE && dbg_allowed) begin
      mem[dbg_addr] <= mem[dbg_addr] & dbg_wdata;
    end
  end

  // ----------------------------------------
  // Data paths and answers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ram_wr     <= 1'b0;
      ram_addr   <= '0;
      ram_wdata  <= 8'h00;
      code_rdata <= 8'h00;
    end else begin
      ram_wr <= xwr && !store_write_enable && !busy;
      if (xwr || xrd) begin
        ram_addr  <= x_addr;
        ram_wdata <= x_wdata;
      end
      if (code_rd && code_allowed) begin
        code_rdata <= mem[code_addr];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dbg_ack     <= 1'b0;
      dbg_refused <= 1'b0;
      dbg_rdata   <= 8'h00;
    end else begin
      dbg_ack     <= dbg_req && !busy;
      dbg_refused <= dbg_req && !busy && !dbg_allowed;
      if (dbg_req && !busy && dbg_cmd == FPG_D_READ && dbg_allowed) begin
        dbg_rdata <= mem[dbg_addr];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flash_err_rst <= 1'b0;
    end else begin
      flash_err_rst <= (flash_wr && key_armed && !fw_allowed) || (code_rd && !code_allowed);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_key_second_arms: assert property (key_state == FPG_K_FIRST && key_wr && !flash_wr
    && key_data == `FPG_KEY_SECOND |=> key_armed) else $error("key not armed");
  a_key_wrong_blocks: assert property (key_state == FPG_K_LOCKED && key_wr && !flash_wr
    && key_data != `FPG_KEY_FIRST |=> key_blocked [*3]) else $error("bad key not blocked");
  a_early_write_blocks: assert property (flash_wr && key_state == FPG_K_LOCKED
    |=> key_blocked) else $error("early write not blocked");
  a_op_relocks_key: assert property (flash_wr && key_armed |=> !key_armed)
    else $error("key stays armed");
  a_enable_only_sw: assert property (!ctl_wr |=> $stable(store_write_enable))
    else $error("write enable changed");
  a_erase_page_len: assert property (flash_wr && key_armed && fw_allowed
    && store_erase_enable |=> stall [*8] ##[505:505] !stall) else $error("erase length");
  a_ram_write_route: assert property (xwr && !store_write_enable && !busy
    |=> ram_wr && ram_addr == $past(x_addr)) else $error("ram write lost");
  a_denied_resets: assert property (flash_wr && key_armed && is_rsv(x_addr)
    |=> flash_err_rst) else $error("no flash error reset");
  a_unarmed_no_stall: assert property (flash_wr && !key_armed |=> !stall)
    else $error("unarmed op started");

  c_page_erase: cover property (flash_wr && key_armed && store_erase_enable ##1 stall);
  c_byte_prog: cover property (flash_wr && key_armed && !store_erase_enable && fw_allowed);
  c_key_block: cover property (key_wr ##1 key_blocked);
  c_dev_wipe: cover property (dbg_req && dbg_cmd == FPG_D_WIPE ##1 stall);
endmodule : fpg_guard

//--- tb/fpg_core_model.sv
/*
  Core model: key, control, data-space and code-space accesses.
  Assumes one clk_sys; every access is a one-cycle pulse set just after an edge.
*/
module fpg_core_model (
  input  wire logic  clk_sys,
  output logic       key_wr,
  output logic [7:0] key_data,
  output logic       ctl_wr,
  output logic       ctl_write_en,
  output logic       ctl_erase_en,
  output logic       xwr,
  output logic       xrd,
  output logic [13:0] x_addr,
  output logic [7:0] x_wdata,
  output logic [13:0] exec_addr,
  output logic       code_rd,
  output logic [13:0] code_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {key_wr, ctl_wr, ctl_write_en, ctl_erase_en, xwr, xrd, code_rd} = 7'h00;
    {key_data, x_wdata} = 16'h0000;
    {x_addr, code_addr} = 28'h0000000;
    exec_addr = 14'h0800;
  end
  task automatic key(input logic [7:0] d);
    @(posedge clk_sys) #10 key_data = d;
    key_wr = 1'b1;
    @(posedge clk_sys) #10 key_wr = 1'b0;
    key_data = ~d;
  endtask : key
  task automatic unlock;
    key(8'ha5);
    key(8'hf1);
  endtask : unlock
  task automatic ctl(input logic we, input logic ee);
    @(posedge clk_sys) #10 {ctl_write_en, ctl_erase_en} = {we, ee};
    ctl_wr = 1'b1;
    @(posedge clk_sys) #10 ctl_wr = 1'b0;
  endtask : ctl
  task automatic xw(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk_sys) #10 {x_addr, x_wdata} = {a, d};
    xwr = 1'b1;
    @(posedge clk_sys) #10 xwr = 1'b0;
    x_wdata = ~d;
  endtask : xw
  task automatic xr(input logic [13:0] a);
    @(posedge clk_sys) #10 x_addr = a;
    xrd = 1'b1;
    @(posedge clk_sys) #10 xrd = 1'b0;
  endtask : xr
  task automatic fetch(input logic [13:0] a);
    @(posedge clk_sys) #10 code_addr = a;
    code_rd = 1'b1;
    @(posedge clk_sys) #10 code_rd = 1'b0;
  endtask : fetch
  task automatic run_at(input logic [13:0] a);
    @(posedge clk_sys) #10 exec_addr = a;
  endtask : run_at
endmodule : fpg_core_model

//--- tb/test_flash_program_erase_guard.sv
/*
  Self-checking bench of the guard: core model on the near side, debug port driven here.
  Assumes fpg_map.svh on the include path; code reads are checked from a queue.
*/
`include "fpg_map.svh"
module test_flash_program_erase_guard
  import fpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, arst_n, key_wr, ctl_wr, ctl_write_en, ctl_erase_en, xwr, xrd, code_rd, dbg_req;
  logic [7:0] key_data, x_wdata, dbg_wdata, ram_wdata, code_rdata, dbg_rdata;
  logic [13:0] x_addr, exec_addr, code_addr, dbg_addr, ram_addr;
  fpg_dbg_t dbg_cmd;
  logic store_write_enable, store_erase_enable, key_armed, key_blocked, stall;
  logic ram_wr, ram_rd, dbg_ack, dbg_refused, flash_err_rst, rd_d;
  logic [7:0] exp_q[$];
  logic [7:0] d0, d1, prog;
  logic [13:0] a;
  int err_total, n_tests, n_err, n, seed;
  fpg_guard i_dut (.clk_sys, .arst_n, .key_wr, .key_data, .ctl_wr, .ctl_write_en, .ctl_erase_en,
    .xwr, .xrd, .x_addr, .x_wdata, .exec_addr, .code_rd, .code_addr, .dbg_req, .dbg_cmd,
    .dbg_addr, .dbg_wdata, .store_write_enable, .store_erase_enable, .key_armed, .key_blocked,
    .stall, .ram_wr, .ram_rd, .ram_addr, .ram_wdata, .code_rdata, .dbg_ack, .dbg_refused,
    .dbg_rdata, .flash_err_rst);
  fpg_core_model c (.clk_sys, .key_wr, .key_data, .ctl_wr, .ctl_write_en, .ctl_erase_en,
    .xwr, .xrd, .x_addr, .x_wdata, .exec_addr, .code_rd, .code_addr);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic dbg(input fpg_dbg_t cm, input logic [13:0] ad, input logic r);
    @(posedge clk_sys) #10 dbg_cmd = cm;
    dbg_addr = ad;
    dbg_req = 1'b1;
    @(posedge clk_sys) #10 dbg_req = 1'b0;
    chk("dbg_ack", dbg_ack, 1'b1);
    chk("dbg_refused", dbg_refused, r);
  endtask : dbg
  task automatic wait_idle(input int lim);
    n = 0;
    while (stall === 1'b1) begin
      @(posedge clk_sys) #10 n++;
      if (n > lim) begin
        err_total++;
        end_sim();
      end
    end
  endtask : wait_idle
  task automatic errs(input int e);
    repeat (3) @(posedge clk_sys);
    #10 chk("flash_err_rst count", n_err, e);
  endtask : errs
  always @(posedge clk_sys) begin
    rd_d <= code_rd;
    if (flash_err_rst === 1'b1) n_err <= n_err + 1;
  end
  always @(negedge clk_sys)
    if (rd_d === 1'b1 && exp_q.size() > 0) chk("code_rdata", code_rdata, exp_q.pop_front());
  initial begin
    arst_n = 1'b0;
    dbg_req = 1'b0;
    dbg_cmd = FPG_D_READ;
    dbg_addr = 14'h0000;
    dbg_wdata = 8'h00;
    {err_total, n_tests, n_err, seed} = {32'd0, 32'd0, 32'd0, 32'd97524};
    repeat (8) @(posedge clk_sys);
    #10 arst_n = 1'b1;
    chk("enables", {store_write_enable, store_erase_enable, key_armed, key_blocked}, 4'h0);
    dbg(FPG_D_WIPE, 14'h0000, 1'b0);
    wait_idle(20000);
    c.fetch(`FPG_LOCK_ADDR);
    exp_q.push_back(`FPG_ERASED);
    $display("test wipe done");
    dbg_wdata = $random(seed);
    dbg(FPG_D_WRITE, 14'h0200, 1'b0);
    exp_q.push_back(dbg_wdata);
    c.fetch(14'h0200);
    c.key(8'ha5);
    repeat (5) @(posedge clk_sys);
    c.key(8'hf1);
    chk("key_armed", key_armed, 1'b1);
    c.ctl(1'b1, 1'b1);
    c.xw(14'h0200 | 14'($unsigned($random(seed)) % 512), 8'h00);
    wait_idle(1000);
    chk("stall cycles", n, 16'd512);
    chk("key_armed", key_armed, 1'b0);
    chk("store_write_enable", store_write_enable, 1'b1);
    exp_q.push_back(`FPG_ERASED);
    c.fetch(14'h0200);
    exp_q.push_back(`FPG_ERASED);
    c.fetch(14'h03ff);
    $display("test erase done");
    a = 14'h0200 | 14'($unsigned($random(seed)) % 512);
    d0 = $random(seed);
    d1 = $random(seed);
    prog = d0 & d1;
    for (int i = 0; i < 2; i++) begin
      c.unlock();
      c.ctl(1'b1, 1'b0);
      c.xw(a, i == 0 ? d0 : d1);
      chk("ram_wr", ram_wr, 1'b0);
      c.ctl(1'b0, 1'b0);
    end
    c.fetch(a);
    exp_q.push_back(prog);
    c.xw(14'h0123, d0);
    chk("ram route", {ram_wr, ram_addr, ram_wdata}, {1'b1, 14'h0123, d0});
    c.ctl(1'b1, 1'b0);
    fork
      c.xr(14'h0042);
      begin
        @(posedge clk_sys) #20 chk("ram_rd", ram_rd, 1'b1);
      end
    join
    chk("key_blocked", key_blocked, 1'b0);
    $display("test program done");
    c.unlock();
    c.xw(14'h3e00 | 14'($unsigned($random(seed)) % 512), d1);
    errs(1);
    c.unlock();
    c.xw(`FPG_LOCK_ADDR, 8'hfd);
    c.ctl(1'b0, 1'b0);
    dbg(FPG_D_READ, 14'h0000, 1'b1);
    dbg(FPG_D_WRITE, 14'h03ff, 1'b1);
    dbg(FPG_D_ERASE, 14'h0400, 1'b0);
    wait_idle(1000);
    chk("dbg erase cycles", n, 16'd512);
    dbg(FPG_D_READ, 14'h3c00, 1'b1);
    c.fetch(14'h0250);
    errs(2);
    c.run_at(14'h0010);
    c.fetch(a);
    exp_q.push_back(prog);
    c.unlock();
    c.ctl(1'b1, 1'b1);
    c.xw(14'h3c00, 8'h00);
    errs(3);
    c.ctl(1'b0, 1'b0);
    c.fetch(`FPG_LOCK_ADDR);
    exp_q.push_back(8'hfd);
    $display("test lock done");
    c.key(8'h5a);
    chk("key_blocked", key_blocked, 1'b1);
    c.unlock();
    chk("key_armed", key_armed, 1'b0);
    @(posedge clk_sys) #10 arst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #10 arst_n = 1'b1;
    chk("key_blocked", key_blocked, 1'b0);
    c.ctl(1'b1, 1'b0);
    c.xw(a, 8'h00);
    chk("key_blocked", key_blocked, 1'b1);
    c.fetch(a);
    exp_q.push_back(prog);
    repeat (4) @(posedge clk_sys);
    chk("queue empty", exp_q.size(), 16'd0);
    $display("test block done");
    end_sim();
  end
endmodule : test_flash_program_erase_guard
